// ### design/tmh_pkg.sv
// tunnel-mode host handshake: shared constants and carrier types
// assumes 100 MHz hclk; serial framing handled by the block itself
package tmh_pkg;
    // ahb-lite register map (byte addresses)
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_RF_CMD = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_QWAIT = 8'h0C;
    localparam logic [7:0] ADDR_AWAIT = 8'h10;
    localparam logic [7:0] ADDR_RESULT = 8'h14;
    // configuration field positions
    localparam int CTRL_SEL_BIT = 0;
    localparam int CTRL_OFFSEL_LSB = 5;
    localparam logic [2:0] OFFSEL_CLOCKED = 3'h7;
    // command codes
    localparam logic [7:0] CMD_QUERY = 8'h28;
    localparam logic [7:0] CMD_ANS_OK = 8'hF8;
    localparam logic [7:0] CMD_ANS_ERR = 8'hE8;
    localparam logic [7:0] RF_RD_JIS = 8'h06;
    localparam logic [7:0] RF_RD_TYB = 8'hB0;
    localparam logic [7:0] RF_WR_JIS = 8'h08;
    localparam logic [7:0] RF_WR_TYB = 8'hD6;
    localparam logic [7:0] RSP_QUERY = 8'h08;
    localparam logic [2:0] MODE_TUNNEL = 3'h4;
    localparam logic [7:0] STATUS_OK = 8'h00;
    // serial idle timeout, plus query and answer wait reset values
    localparam int CLK_MHZ = 100;
    localparam int SER_TO_MS = 12;
    localparam int SER_TO_CYC = SER_TO_MS * 1000 * CLK_MHZ;
    localparam logic [31:0] QWAIT_RST = 32'h000F4240;
    localparam logic [31:0] AWAIT_RST = 32'h000F4240;

    typedef enum logic [2:0] {
        ST_IDLE, ST_IRQ, ST_QWAIT, ST_QRSP, ST_AWAIT, ST_ARSP
    } tmh_state_e;

    typedef struct packed {
        logic [7:0] code;
        logic [15:0] addr;
        logic [7:0] len;
    } tmh_rfcmd_s;

    typedef struct packed {
        tmh_state_e st;
        tmh_rfcmd_s cmd;
        logic irq_low;
        logic [31:0] tmr;
        logic [7:0] retry;
        logic timeout;
        logic [7:0] result;
        logic result_v;
        logic [7:0] ctrl;
        logic [31:0] qwait;
        logic [31:0] await_lim;
        logic [2:0] sck_sync;
        logic [1:0] sin_sync;
        logic [7:0] rx_sh;
        logic [2:0] rx_cnt;
        logic [7:0] tx_sh;
        logic [1:0] tx_idx;
        logic rsp_busy;
        logic [31:0] idle_cnt;
        logic [7:0] haddr;
        logic hwrite;
        logic hsel;
        logic [31:0] hrdata;
    } tmh_regs_s;
endpackage

// ### design/tmh_core.sv
// tunnel-mode host handshake: irq, query/answer sequencing, timeouts
// assumes ahb-lite master on hclk; serial clock and data are raw pins
//
// Register access over AHB-Lite and the address map are this design's own decisions.
`timescale 1ns/1ns
module tmh_core
    import tmh_pkg::*;
#(
    parameter int SER_TO = SER_TO_CYC
)
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic sck_pin,
    input wire logic sdi_pin,
    output logic sdo_pin,
    input wire logic interface_select_pin,
    input wire logic host_side_supply,
    input wire logic [31:0] async_link_wait_limit,
    output logic irq_n_out,
    output logic irq_n_oe
);
    tmh_regs_s r, n;
    logic sck_rise, sck_fall, async_mode, byte_done;
    logic [7:0] rx_byte, rsp_byte;
    logic [31:0] q_limit;

    // select serial flavour from pin or supply-off config
    assign async_mode = host_side_supply ? interface_select_pin
        : (r.ctrl[CTRL_OFFSEL_LSB +: 3] != OFFSEL_CLOCKED);
    // async wait is the longer of both limits
    assign q_limit = (async_mode && async_link_wait_limit > r.qwait)
        ? async_link_wait_limit : r.qwait;
    // edges read only the second and third sync stages
    assign sck_rise = r.sck_sync[1] & ~r.sck_sync[2];
    assign sck_fall = ~r.sck_sync[1] & r.sck_sync[2];
    assign rx_byte = {r.rx_sh[6:0], r.sin_sync[1]};
    assign byte_done = sck_rise && (r.rx_cnt == 3'h7);

    // reply bytes: code, addr hi (mode tagged), addr lo, len
    always_comb
    begin
        unique case (r.tx_idx)
            2'h0: rsp_byte = RSP_QUERY;
            2'h1: rsp_byte = {1'b0, MODE_TUNNEL, r.cmd.addr[11:8]};
            2'h2: rsp_byte = r.cmd.addr[7:0];
            default: rsp_byte = r.cmd.len;
        endcase
    end

    // open-drain interrupt: only the pin, never the data line
    assign irq_n_out = 1'b0;
    assign irq_n_oe = r.irq_low;
    assign sdo_pin = r.tx_sh[7];
    assign hrdata = r.hrdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // whole next state
    always_comb
    begin
        n = r;
        n.sck_sync = {r.sck_sync[1:0], sck_pin};
        n.sin_sync = {r.sin_sync[0], sdi_pin};
        // bus address phase capture
        if (hready)
        begin
            n.hsel = hsel && htrans[1];
            n.haddr = haddr[7:0];
            n.hwrite = hwrite;
        end
        // serial shift: sample on rise, drive on fall
        if (sck_rise)
        begin
            n.rx_sh = rx_byte;
            n.rx_cnt = r.rx_cnt + 3'h1;
            n.idle_cnt = '0;
        end
        else if (r.rx_cnt != 3'h0 || r.rsp_busy)
        begin
            // partial byte stalled too long: reinitialise link
            if (r.idle_cnt >= SER_TO[31:0])
            begin
                n.rx_cnt = 3'h0;
                n.rsp_busy = 1'b0;
                n.idle_cnt = '0;
            end
            else
                n.idle_cnt = r.idle_cnt + 32'h1;
        end
        if (sck_fall && r.rx_cnt == 3'h0 && r.rsp_busy)
        begin
            n.tx_sh = rsp_byte;
            n.tx_idx = r.tx_idx + 2'h1;
        end
        else if (sck_fall)
            n.tx_sh = {r.tx_sh[6:0], 1'b0};
        // busy until the last reply byte is clocked out; bytes the host
        // clocks in meanwhile are dummies and must not be decoded
        if (byte_done && r.rsp_busy && r.tx_idx == 2'h0)
            n.rsp_busy = 1'b0;
        // timer runs except while a reply is pending
        if (!r.rsp_busy)
            n.tmr = r.tmr + 32'h1;
        unique case (r.st)
            ST_IDLE:
                ;
            ST_IRQ:
            begin
                // start query timer; low drive drops at first serial clock in query wait
                n.st = ST_QWAIT;
                n.tmr = '0;
            end
            ST_QWAIT:
            begin
                if (sck_rise)
                    n.irq_low = 1'b0;
                if (byte_done && rx_byte == CMD_QUERY)
                begin
                    n.st = ST_QRSP;
                    n.rsp_busy = 1'b1;
                    n.tx_idx = 2'h0;
                end
                else if (byte_done)
                    n.retry = r.retry + 8'h1;
                else if (r.tmr >= q_limit)
                begin
                    // no retried interrupt; abandon
                    n.timeout = 1'b1;
                    n.irq_low = 1'b0;
                    n.st = ST_IDLE;
                end
            end
            ST_QRSP:
                if (!r.rsp_busy)
                begin
                    n.st = ST_AWAIT;
                    n.tmr = '0;
                end
            ST_AWAIT:
            begin
                if (byte_done && !r.rsp_busy && (rx_byte == CMD_ANS_OK
                    || rx_byte == CMD_ANS_ERR))
                begin
                    n.result = rx_byte;
                    n.result_v = 1'b1;
                    n.st = ST_IDLE;
                end
                else if (byte_done && !r.rsp_busy)
                begin
                    // unrelated command: pause timer until reply out
                    n.rsp_busy = 1'b1;
                    n.tx_idx = 2'h3;
                    n.cmd.len = STATUS_OK;
                end
                else if (r.tmr >= r.await_lim)
                begin
                    n.timeout = 1'b1;
                    n.st = ST_IDLE;
                end
            end
            default:
                n.st = ST_IDLE;
        endcase
        // bus writes, data phase
        if (r.hsel && r.hwrite)
        begin
            unique case (r.haddr)
                ADDR_CTRL: n.ctrl = hwdata[7:0];
                ADDR_QWAIT: n.qwait = hwdata;
                ADDR_AWAIT: n.await_lim = hwdata;
                ADDR_RF_CMD:
                    // only rf read/write codes start a tunnel
                    if (r.st == ST_IDLE && (hwdata[31:24] == RF_RD_JIS
                        || hwdata[31:24] == RF_RD_TYB
                        || hwdata[31:24] == RF_WR_JIS
                        || hwdata[31:24] == RF_WR_TYB))
                    begin
                        n.cmd = hwdata;
                        n.irq_low = 1'b1;
                        n.st = ST_IRQ;
                        n.retry = '0;
                        n.timeout = 1'b0;
                        n.result_v = 1'b0;
                    end
                default:
                    ;
            endcase
        end
        // bus reads, registered from the address phase, answered in the data phase
        n.hrdata = '0;
        if (hready && hsel && htrans[1] && !hwrite)
        begin
            unique case (haddr[7:0])
                ADDR_CTRL: n.hrdata = {24'h0, r.ctrl};
                ADDR_RF_CMD: n.hrdata = r.cmd;
                ADDR_STATUS: n.hrdata = {13'h0, r.st, r.retry,
                    r.timeout, r.result_v, r.irq_low, async_mode, 4'h0};
                ADDR_QWAIT: n.hrdata = r.qwait;
                ADDR_AWAIT: n.hrdata = r.await_lim;
                ADDR_RESULT: n.hrdata = {24'h0, r.result};
                default: n.hrdata = '0;
            endcase
        end
    end

    // single state register
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            r <= '0;
            r.st <= ST_IDLE;
            r.qwait <= QWAIT_RST;
            r.await_lim <= AWAIT_RST;
        end
        else
            r <= n;
    end

    // interrupt rises with an accepted rf command
    property p_irq_on_cmd;
        @(posedge hclk) disable iff (!hresetn)
        (r.st == ST_IDLE && n.st == ST_IRQ) |=> r.irq_low;
    endproperty
    a_irq_on_cmd: assert property (p_irq_on_cmd)
        else $error("interrupt not raised");

    property p_irq_release;
        @(posedge hclk) disable iff (!hresetn)
        (r.st == ST_QWAIT && sck_rise) |=> !r.irq_low;
    endproperty
    a_irq_release: assert property (p_irq_release)
        else $error("interrupt not released on clock");

    property p_tmr_start;
        @(posedge hclk) disable iff (!hresetn)
        r.st == ST_IRQ |=> r.tmr == 32'h0;
    endproperty
    a_tmr_start: assert property (p_tmr_start)
        else $error("query timer not started");

    property p_q_timeout;
        @(posedge hclk) disable iff (!hresetn)
        (r.st == ST_QWAIT && !byte_done && r.tmr >= q_limit)
            |=> r.timeout && r.st == ST_IDLE && !r.irq_low;
    endproperty
    a_q_timeout: assert property (p_q_timeout)
        else $error("query timeout missed");

    property p_retry;
        @(posedge hclk) disable iff (!hresetn)
        (r.st == ST_QWAIT && byte_done && rx_byte != CMD_QUERY)
            |=> r.retry == $past(r.retry) + 8'h1;
    endproperty
    a_retry: assert property (p_retry)
        else $error("retry not counted");

    property p_query_go;
        @(posedge hclk) disable iff (!hresetn)
        (r.st == ST_QWAIT && byte_done && rx_byte == CMD_QUERY)
            |=> r.st == ST_QRSP && r.rsp_busy;
    endproperty
    a_query_go: assert property (p_query_go)
        else $error("query not recognised");

    property p_ans_tmr;
        @(posedge hclk) disable iff (!hresetn)
        (r.st == ST_QRSP && !r.rsp_busy) |=> r.st == ST_AWAIT
            && r.tmr == 32'h0;
    endproperty
    a_ans_tmr: assert property (p_ans_tmr)
        else $error("answer timer not started");

    property p_pause;
        @(posedge hclk) disable iff (!hresetn)
        (r.st == ST_AWAIT && r.rsp_busy && !byte_done)
            |=> $stable(r.tmr) || r.st != ST_AWAIT;
    endproperty
    a_pause: assert property (p_pause)
        else $error("answer timer ran during reply");

    property p_mode_bits;
        @(posedge hclk) disable iff (!hresetn)
        (sck_fall && r.rx_cnt == 3'h0 && r.rsp_busy && r.tx_idx == 2'h1)
            |=> r.tx_sh[7:4] == {1'b0, MODE_TUNNEL};
    endproperty
    a_mode_bits: assert property (p_mode_bits)
        else $error("mode bits wrong");

    property p_ans_timeout;
        @(posedge hclk) disable iff (!hresetn)
        (r.st == ST_AWAIT && !byte_done && r.tmr >= r.await_lim)
            |=> r.timeout && r.st == ST_IDLE;
    endproperty
    a_ans_timeout: assert property (p_ans_timeout)
        else $error("answer timeout missed");

    c_query: cover property (@(posedge hclk) disable iff (!hresetn)
        r.st == ST_QRSP ##[1:1000] r.st == ST_AWAIT);
    c_answer: cover property (@(posedge hclk) disable iff (!hresetn)
        r.st == ST_AWAIT ##1 r.result_v);
    c_timeout: cover property (@(posedge hclk) disable iff (!hresetn)
        $rose(r.timeout));
    c_retry: cover property (@(posedge hclk) disable iff (!hresetn)
        (r.st == ST_QWAIT) ##1 (r.retry != 8'h0));
    c_other: cover property (@(posedge hclk) disable iff (!hresetn)
        (r.st == ST_AWAIT && r.rsp_busy) ##1 !r.rsp_busy);
endmodule

// ### verification/tmh_host_model.sv
// host model: clocked serial master on the tunnel link
// assumes sck idles low between frames and the device samples on rise
`timescale 1ns/1ns
module tmh_host_model
(
    output logic sck_pin,
    output logic sdi_pin,
    input wire logic sdo_pin
);
    initial
    begin
        sck_pin = 1'b0;
        sdi_pin = 1'b0;
    end
    // n bits msb first, 160 ns a bit; clock stands still afterwards
    task automatic shift(input logic [31:0] tx, input int n,
        output logic [31:0] rx);
        rx = '0;
        for (int i = n - 1; i >= 0; i--)
        begin
            sdi_pin = tx[i];
            #80 sck_pin = 1'b1;
            rx = {rx[30:0], sdo_pin};
            #80 sck_pin = 1'b0;
        end
        // released line shows the inverse, never a stale copy
        sdi_pin = ~sdi_pin;
    endtask
endmodule

// ### verification/tunnel_mode_host_handshake_tb_top.sv
// testbench: ahb-lite master, host model, tunnel sequences, timeouts
// assumes tmh_core with a shortened serial idle timeout
`timescale 1ns/1ns
module tunnel_mode_host_handshake_tb_top import tmh_pkg::*;;
    localparam int SER_TO_TB = 2000;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = '0;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = '0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic sck_pin;
    logic sdi_pin;
    logic sdo_pin;
    logic interface_select_pin = 1'b0;
    logic host_side_supply = 1'b1;
    logic [31:0] async_link_wait_limit = 32'h78;
    logic irq_n_out;
    logic irq_n_oe;
    wire irq_n = irq_n_oe ? irq_n_out : 1'b1; // pulled up when released
    int bad_count = 0;
    int samples_checked = 0;
    int w;
    logic [31:0] seed = 32'hAF2C4302;
    logic [31:0] rx;

    tmh_core #(.SER_TO(SER_TO_TB)) u_tmh_core (.hclk(hclk),
        .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .sck_pin(sck_pin), .sdi_pin(sdi_pin),
        .sdo_pin(sdo_pin), .interface_select_pin(interface_select_pin),
        .host_side_supply(host_side_supply),
        .async_link_wait_limit(async_link_wait_limit),
        .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe));
    tmh_host_model u_tmh_host_model (.sck_pin(sck_pin), .sdi_pin(sdi_pin),
        .sdo_pin(sdo_pin));

    always #5 hclk = ~hclk;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // expected query reply: code, tunnel-tagged address, length
    function automatic logic [31:0] exp_rsp(input logic [15:0] a,
        input logic [7:0] n);
        return {RSP_QUERY, 1'b0, MODE_TUNNEL, a[11:8], a[7:0], n};
    endfunction

    task automatic chk(input string name, input logic [31:0] seen,
        input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // one single transfer; read data taken while it stands
    task automatic ahb(input logic wr, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= wr;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask

    // pre: 1 stray bytes in both waits, 2 a broken partial frame
    task automatic tunnel(input logic [7:0] code, input logic [7:0] ans,
        input int pre);
        logic [15:0] a;
        logic [7:0] n;
        logic [31:0] r;
        seed = lfsr(seed);
        a = seed[15:0];
        n = seed[23:16];
        ahb(1'b1, ADDR_RF_CMD, {code, a, n}, r);
        repeat (3) @(posedge hclk);
        chk("irq_oe", irq_n_oe, 32'h1);
        chk("irq_pin", irq_n, 32'h0);
        if (pre == 1)
        begin
            u_tmh_host_model.shift(32'h00, 8, r);
            ahb(1'b0, ADDR_STATUS, 32'h0, r);
            chk("retry", r[15:8], 32'h1);
        end
        if (pre == 2)
        begin
            u_tmh_host_model.shift(32'h5, 3, r);
            #(SER_TO_TB * 20);
        end
        u_tmh_host_model.shift({24'h0, CMD_QUERY}, 8, r);
        u_tmh_host_model.shift(32'hFFFFFFFF, 32, r);
        chk("query_rsp", r, exp_rsp(a, n));
        chk("irq_rel", irq_n_oe, 32'h0);
        if (pre == 1)
        begin
            u_tmh_host_model.shift(32'h00, 8, r);
            u_tmh_host_model.shift(32'hFF, 8, r);
            chk("other_rsp", r[7:0], STATUS_OK);
        end
        u_tmh_host_model.shift({24'h0, ans}, 8, r);
        repeat (10) @(posedge hclk);
        ahb(1'b0, ADDR_RESULT, 32'h0, r);
        chk("result", r[7:0], ans);
        $display("test tunnel %h done", code);
    endtask

    initial
    begin
        #800000;
        bad_count++;
        give_verdict;
    end

    initial
    begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        ahb(1'b0, ADDR_QWAIT, 32'h0, rx);
        chk("qwait_rst", rx, QWAIT_RST);
        ahb(1'b0, ADDR_AWAIT, 32'h0, rx);
        chk("await_rst", rx, AWAIT_RST);
        ahb(1'b0, 8'h18, 32'h0, rx);
        chk("unmapped", rx, 32'h0);
        ahb(1'b1, ADDR_RF_CMD, 32'h55000001, rx);
        repeat (3) @(posedge hclk);
        chk("bad_code", irq_n_oe, 32'h0);
        $display("test registers done");
        tunnel(RF_RD_JIS, CMD_ANS_OK, 0);
        tunnel(RF_RD_TYB, CMD_ANS_ERR, 2);
        tunnel(RF_WR_JIS, CMD_ANS_OK, 1);
        host_side_supply <= 1'b0;
        ahb(1'b1, ADDR_CTRL, 32'hE0, rx);
        tunnel(RF_WR_TYB, CMD_ANS_ERR, 0);
        host_side_supply <= 1'b1;
        // answer never comes: device gives up and goes idle
        ahb(1'b1, ADDR_AWAIT, 32'h28, rx);
        ahb(1'b1, ADDR_RF_CMD, {RF_WR_JIS, 16'h0123, 8'h2}, rx);
        u_tmh_host_model.shift({24'h0, CMD_QUERY}, 8, rx);
        u_tmh_host_model.shift(32'hFFFFFFFF, 32, rx);
        chk("rsp_fixed", rx, exp_rsp(16'h0123, 8'h2));
        repeat (80) @(posedge hclk);
        ahb(1'b0, ADDR_STATUS, 32'h0, rx);
        chk("a_timeout", rx[7], 32'h1);
        chk("a_idle", rx[18:16], ST_IDLE);
        ahb(1'b1, ADDR_QWAIT, 32'h28, rx);
        ahb(1'b1, ADDR_RF_CMD, {RF_RD_JIS, 16'h0, 8'h1}, rx);
        repeat (80) @(posedge hclk);
        ahb(1'b0, ADDR_STATUS, 32'h0, rx);
        chk("q_timeout", rx[7], 32'h1);
        chk("tmo_irq", irq_n_oe, 32'h0);
        w = 0;
        repeat (200)
        begin
            @(posedge hclk);
            if (irq_n_oe !== 1'b0)
                w++;
        end
        chk("no_resend", w, 32'h0);
        interface_select_pin <= 1'b1;
        ahb(1'b1, ADDR_RF_CMD, {RF_RD_TYB, 16'h0, 8'h1}, rx);
        repeat (60) @(posedge hclk);
        ahb(1'b0, ADDR_STATUS, 32'h0, rx);
        chk("async_wait", rx[7], 32'h0);
        repeat (100) @(posedge hclk);
        ahb(1'b0, ADDR_STATUS, 32'h0, rx);
        chk("async_tmo", rx[7], 32'h1);
        $display("test timeouts done");
        give_verdict;
    end
endmodule
